// >>> hw/scpllc_dev.sv
/*
 Device end: serial register port and synthesizer control registers,
 with the band calibration timer and lock indication.
 Assumes the link pins are asynchronous to I_CLK and sampled by it.
*/
// Our own choice: the APB register port.
`timescale 1ns/1ps

module scpllc_dev
	import scpllc_pkg::*;
#(
	parameter int CAL_CYCLES = `SCPLLC_CAL_PFD_CYCLES
) (
	// Clock and reset
	input  wire logic          I_CLK,
	input  wire logic          I_SRST,
	// Phase detector reference tick, one pulse per cycle
	input  wire logic          I_PFD_TICK,
	// Serial link
	scpllc_if.dev              LINK,
	// Synthesizer controls
	output scpllc_pkg::scpllc_data_t O_INT_WORD,
	output scpllc_pkg::scpllc_data_t O_FRAC_WORD,
	output scpllc_pkg::scpllc_data_t O_MOD_WORD,
	output logic               O_FRAC_MODE,
	output logic [1:0]         O_OUT_DIV_SEL,
	output logic [3:0]         O_OUT_DIV_RATIO,
	output logic [1:0]         O_OSC_OUTPUT_LEVEL,
	output logic [2:0]         O_OSC_CORE_SELECT,
	output logic               O_EXT_OSC,
	output logic               O_OSC_OUTPUT_ENABLE,
	output logic [2:0]         O_STATUS_MUX_SELECT,
	output logic               O_CAL_BUSY,
	output logic               O_LOCKED,
	output logic               O_STATUS_MUX_PIN
);
	import scpllc_pkg::*;

	localparam int DW = `SCPLLC_DATA_BITS;
	localparam int AW = `SCPLLC_ADDR_BITS;

	logic sclk_l, cs_n_l, sdio_l;
	logic sclk_prev_q;
	logic [4:0]  bit_cnt_q;
	logic [AW:0] hdr_q;
	logic [DW-1:0] dsh_q;
	logic [4:0]  dcnt_q;
	logic [DW-1:0] rsh_q;
	logic        oe_q;
	logic        in_frame_q;
	logic [DW-1:0] r01_q, r02_q, r03_q, r04_q, r21_q, r22_q;
	scpllc_cal_t cal_q;
	logic [12:0] cal_cnt_q;
	logic [6:0]  set_cnt_q;

	scpllc_sync u_sync_sclk (.i_clk(I_CLK), .i_srst(I_SRST),
		.i_pin(LINK.sclk), .o_lvl(sclk_l));
	scpllc_sync #(.RST_VAL(1'b1)) u_sync_cs (.i_clk(I_CLK),
		.i_srst(I_SRST), .i_pin(LINK.cs_n), .o_lvl(cs_n_l));
	scpllc_sync u_sync_sdio (.i_clk(I_CLK), .i_srst(I_SRST),
		.i_pin(LINK.sdio), .o_lvl(sdio_l));

	wire rise       = sclk_l & ~sclk_prev_q & ~cs_n_l;
	wire fall       = ~sclk_l & sclk_prev_q & ~cs_n_l;
	wire hdr_done   = (bit_cnt_q == 5'(AW + 1));
	wire is_read    = hdr_q[0];
	wire [AW-1:0] addr = hdr_q[AW:1];
	wire end_frame  = cs_n_l & in_frame_q;

	// Short write: unshifted low bits keep the old contents.
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
		input logic [DW-1:0] sh, input logic [4:0] n);
		logic [DW-1:0] m;
		m = (n >= 5'(DW)) ? {DW{1'b1}} : ~({DW{1'b1}} >> n);
		merge = ({DW{1'b0}} | (sh << (5'(DW) - n)) & m) | (old & ~m);
	endfunction : merge

	wire [DW-1:0] wr_val_01 = merge(r01_q, dsh_q, dcnt_q);
	wire [DW-1:0] wr_val_02 = merge(r02_q, dsh_q, dcnt_q);
	wire [DW-1:0] wr_val_03 = merge(r03_q, dsh_q, dcnt_q);
	wire [DW-1:0] wr_val_04 = merge(r04_q, dsh_q, dcnt_q);
	wire [DW-1:0] wr_val_21 = merge(r21_q, dsh_q, dcnt_q);
	wire [DW-1:0] wr_val_22 = merge(r22_q, dsh_q, dcnt_q);
	wire do_wr = end_frame & hdr_done & ~is_read & (dcnt_q != 5'h00);
	wire wr_div = do_wr & ((addr == `SCPLLC_OFS_INT_DIV) |
		(addr == `SCPLLC_OFS_FRAC_NUM) |
		(addr == `SCPLLC_OFS_MODULUS));

	// The word is fetched while the read flag is still arriving, so the
	// address sits one place lower in the header than it does later on.
	wire [AW-1:0] rd_addr = hdr_q[AW-1:0];
	wire [DW-1:0] rd_word =
		(rd_addr == `SCPLLC_OFS_LO_OUT_EN) ? r01_q :
		(rd_addr == `SCPLLC_OFS_INT_DIV)   ? r02_q :
		(rd_addr == `SCPLLC_OFS_FRAC_NUM)  ? r03_q :
		(rd_addr == `SCPLLC_OFS_MODULUS)   ? r04_q :
		(rd_addr == `SCPLLC_OFS_MUX_SEL)   ? r21_q :
		(rd_addr == `SCPLLC_OFS_LO_PATH)   ? r22_q : 16'h0000;
	// Read flag arriving on the last header rise: load the data word, which is then
	// shifted out most significant bit first.
	wire hdr_last = rise & (bit_cnt_q == 5'(AW));
	wire rd_start = hdr_last & sdio_l;

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			sclk_prev_q <= 1'b0;
			in_frame_q  <= 1'b0;
			bit_cnt_q   <= 5'h00;
			hdr_q       <= 8'h00;
			dsh_q       <= 16'h0000;
			dcnt_q      <= 5'h00;
		end else begin
			sclk_prev_q <= sclk_l;
			if (cs_n_l) begin
				in_frame_q <= 1'b0;
				bit_cnt_q  <= 5'h00;
				dcnt_q     <= 5'h00;
			end else if (rise) begin
				in_frame_q <= 1'b1;
				if (!hdr_done) begin
					hdr_q     <= {hdr_q[AW-1:0], sdio_l};
					bit_cnt_q <= bit_cnt_q + 5'h01;
				end else begin
					dsh_q <= {dsh_q[DW-2:0], sdio_l};
					if (dcnt_q != 5'(DW))
						dcnt_q <= dcnt_q + 5'h01;
				end
			end
		end
	end

	// Device drives from the falling edge after the read flag.
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			oe_q  <= 1'b0;
			rsh_q <= 16'h0000;
		end else if (cs_n_l) begin
			oe_q <= 1'b0;
		end else if (rd_start) begin
			rsh_q <= rd_word;
		end else if (fall & hdr_done & is_read) begin
			if (oe_q)
				rsh_q <= {rsh_q[DW-2:0], 1'b0};
			oe_q <= 1'b1;
		end
	end

	assign LINK.dev_sdio_o  = rsh_q[DW-1];
	assign LINK.dev_sdio_oe = oe_q;

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			r01_q <= `SCPLLC_RST_REG;
			r02_q <= `SCPLLC_RST_REG;  // mode bit 0: fractional
			r03_q <= `SCPLLC_RST_REG;
			r04_q <= `SCPLLC_RST_REG;
			r21_q <= `SCPLLC_RST_REG;  // select 0 is lock detect
			r22_q <= `SCPLLC_RST_REG;
		end else if (do_wr) begin
			if (addr == `SCPLLC_OFS_LO_OUT_EN) r01_q <= wr_val_01;
			if (addr == `SCPLLC_OFS_INT_DIV)   r02_q <= wr_val_02;
			if (addr == `SCPLLC_OFS_FRAC_NUM)  r03_q <= wr_val_03;
			if (addr == `SCPLLC_OFS_MODULUS)   r04_q <= wr_val_04;
			if (addr == `SCPLLC_OFS_MUX_SEL)   r21_q <= wr_val_21;
			if (addr == `SCPLLC_OFS_LO_PATH)   r22_q <= wr_val_22;
		end
	end

	// A divider write during a calibration restarts it from zero.
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			cal_q     <= SCPLLC_CAL_IDLE;
			cal_cnt_q <= 13'h0000;
			set_cnt_q <= 7'h00;
		end else if (wr_div) begin
			cal_q     <= SCPLLC_CAL_RUN;
			cal_cnt_q <= 13'h0000;
			set_cnt_q <= 7'h00;
		end else begin
			unique case (cal_q)
			SCPLLC_CAL_IDLE: begin
			end
			SCPLLC_CAL_RUN: if (I_PFD_TICK) begin
				cal_cnt_q <= cal_cnt_q + 13'h0001;
				if (cal_cnt_q == 13'(CAL_CYCLES - 1))
					cal_q <= SCPLLC_CAL_SETTLE;
			end
			SCPLLC_CAL_SETTLE: if (I_PFD_TICK) begin
				set_cnt_q <= set_cnt_q + 7'h01;
				if (set_cnt_q == 7'(`SCPLLC_SETTLE_CYCLES - 1))
					cal_q <= SCPLLC_CAL_IDLE;
			end
			default: cal_q <= SCPLLC_CAL_IDLE;
			endcase
		end
	end

	wire locked = (cal_q == SCPLLC_CAL_IDLE);
	wire [2:0] mux_sel = r21_q[`SCPLLC_MUX_SEL_HI:`SCPLLC_MUX_SEL_LO];

	assign O_INT_WORD          = r02_q;
	assign O_FRAC_WORD         = r03_q;
	assign O_MOD_WORD          = r04_q;
	assign O_FRAC_MODE         = ~r02_q[`SCPLLC_BIT_DIV_MODE];
	assign O_OUT_DIV_SEL       = r22_q[`SCPLLC_ODIV_HI:`SCPLLC_ODIV_LO];
	assign O_OUT_DIV_RATIO     = 4'h1 << O_OUT_DIV_SEL;
	assign O_OSC_OUTPUT_LEVEL  = r22_q[`SCPLLC_LVL_HI:`SCPLLC_LVL_LO];
	assign O_OSC_CORE_SELECT   = r22_q[`SCPLLC_CORE_HI:`SCPLLC_CORE_LO];
	assign O_EXT_OSC           = (O_OSC_CORE_SELECT == 3'h3);
	assign O_OSC_OUTPUT_ENABLE = r01_q[`SCPLLC_BIT_OSC_OUT_EN];
	assign O_STATUS_MUX_SELECT = mux_sel;
	assign O_CAL_BUSY          = (cal_q == SCPLLC_CAL_RUN);
	assign O_LOCKED            = locked;
	// Other selections carry the reference tick as a plain view.
	assign O_STATUS_MUX_PIN = (mux_sel == 3'h0) ? locked : I_PFD_TICK;
endmodule : scpllc_dev

// >>> hw/scpllc_host.sv
/*
 Host end: APB slave with control, status and read-data registers that
 drives three-wire frames, generating the serial clock by division.
 Assumes APB master on I_CLK; link data in sampled through synchroniser.
*/
`timescale 1ns/1ps

module scpllc_host
	import scpllc_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SRST,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic [31:0]      O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Serial link
	scpllc_if.host           LINK
);
	import scpllc_pkg::*;

	scpllc_hst_t st_q;
	logic [23:0] frame_q;
	logic [4:0]  nbits_q;
	logic [4:0]  bit_q;
	logic [3:0]  div_q;
	logic        sclk_q, cs_n_q, oe_q, rd_q;
	logic [15:0] rdata_q;
	logic [31:0] prdata_q;
	logic        sdio_l;

	scpllc_sync u_sync_sdio (.i_clk(I_CLK), .i_srst(I_SRST),
		.i_pin(LINK.sdio), .o_lvl(sdio_l));

	wire apb_acc  = I_PSEL & I_PENABLE;
	wire sel_ctrl = (I_PADDR == `SCPLLC_APB_CTRL);
	wire sel_stat = (I_PADDR == `SCPLLC_APB_STATUS);
	wire sel_rdat = (I_PADDR == `SCPLLC_APB_RDATA);
	wire busy     = (st_q != SCPLLC_HS_IDLE);
	// CTRL: [15:0] data, [22:16] addr, [23] read, [28:24] data bits.
	wire start = apb_acc & I_PWRITE & sel_ctrl & ~busy;
	wire half  = (div_q == 4'(`SCPLLC_SCLK_HALF - 1));
	wire last  = (bit_q == nbits_q);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			st_q    <= SCPLLC_HS_IDLE;
			frame_q <= 24'h000000;
			nbits_q <= 5'h00;
			bit_q   <= 5'h00;
			div_q   <= 4'h0;
			sclk_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			oe_q    <= 1'b0;
			rd_q    <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			div_q <= (half | ~busy) ? 4'h0 : div_q + 4'h1;
			unique case (st_q)
			SCPLLC_HS_IDLE: if (start) begin
				frame_q <= {I_PWDATA[22:16], I_PWDATA[23],
					I_PWDATA[15:0]};
				rd_q    <= I_PWDATA[23];
				nbits_q <= 5'h08 + I_PWDATA[28:24];
				bit_q   <= 5'h00;
				cs_n_q  <= 1'b0;
				oe_q    <= 1'b1;
				st_q    <= SCPLLC_HS_LEAD;
			end
			SCPLLC_HS_LEAD: if (half)
				st_q <= SCPLLC_HS_SHIFT;
			SCPLLC_HS_SHIFT: if (half) begin
				if (!sclk_q) begin
					sclk_q <= 1'b1;  // data stable before rise
					bit_q  <= bit_q + 5'h01;
					if (rd_q && bit_q >= 5'h08)
						rdata_q <= {rdata_q[14:0], sdio_l};
				end else begin
					sclk_q  <= 1'b0;
					frame_q <= {frame_q[22:0], 1'b0};
					if (rd_q && bit_q == 5'h08)
						oe_q <= 1'b0;
					if (last)
						st_q <= SCPLLC_HS_TAIL;
				end
			end
			SCPLLC_HS_TAIL: if (half) begin
				cs_n_q <= 1'b1;
				oe_q   <= 1'b0;
				st_q   <= SCPLLC_HS_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST)
			prdata_q <= 32'h00000000;
		else if (I_PSEL & ~I_PENABLE)
			prdata_q <= (I_PADDR == `SCPLLC_APB_STATUS) ? {31'h0, busy} :
				(I_PADDR == `SCPLLC_APB_RDATA) ? {16'h0, rdata_q} :
				32'h00000000;
	end

	assign O_PRDATA  = prdata_q;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = apb_acc & ~(sel_ctrl | sel_stat | sel_rdat);
	assign LINK.sclk         = sclk_q;
	assign LINK.cs_n         = cs_n_q;
	assign LINK.host_sdio_o  = frame_q[23];
	assign LINK.host_sdio_oe = oe_q;
endmodule : scpllc_host

// >>> hw/scpllc_sync.sv
/*
 Three-stage synchroniser for link pins; a change is accepted once the
 second and third stages agree.
 Assumes a single destination clock.
*/
`timescale 1ns/1ps

module scpllc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Pin in, filtered level out
	input  wire logic i_pin,
	output logic      o_lvl
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;
	wire  agree = (s2_q == s3_q);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s1_q  <= RST_VAL;
			s2_q  <= RST_VAL;
			s3_q  <= RST_VAL;
			lvl_q <= RST_VAL;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree)
				lvl_q <= s3_q;
		end
	end

	assign o_lvl = lvl_q;
endmodule : scpllc_sync

// >>> inc/scpllc_if.sv
/*
 Three-wire link between the host serial controller and the device.
 The shared data wire is resolved from the two output enables here.
*/
`timescale 1ns/1ps

interface scpllc_if;
	logic sclk;
	logic cs_n;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic sdio;

	// Host wins only if both drive, which marks a protocol fault anyway.
	assign sdio = host_sdio_oe ? host_sdio_o :
		(dev_sdio_oe ? dev_sdio_o : 1'b1);

	modport host (
		output sclk, cs_n, host_sdio_o, host_sdio_oe,
		input  sdio
	);
	modport dev (
		input  sclk, cs_n, sdio,
		output dev_sdio_o, dev_sdio_oe
	);
endinterface : scpllc_if

// >>> inc/scpllc_params.svh
/*
 Timing counts, register offsets and field positions for the serial
 configuration port and its synthesizer controls.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SCPLLC_PARAMS_SVH
`define SCPLLC_PARAMS_SVH

`define SCPLLC_ADDR_BITS        7
`define SCPLLC_DATA_BITS        16
`define SCPLLC_FRAME_BITS       24
`define SCPLLC_OFS_LO_OUT_EN    7'h01
`define SCPLLC_OFS_INT_DIV      7'h02
`define SCPLLC_OFS_FRAC_NUM     7'h03
`define SCPLLC_OFS_MODULUS      7'h04
`define SCPLLC_OFS_MUX_SEL      7'h21
`define SCPLLC_OFS_LO_PATH      7'h22
`define SCPLLC_BIT_OSC_OUT_EN   7
`define SCPLLC_BIT_DIV_MODE     11
`define SCPLLC_MUX_SEL_HI       6
`define SCPLLC_MUX_SEL_LO       4
`define SCPLLC_ODIV_HI          4
`define SCPLLC_ODIV_LO          3
`define SCPLLC_LVL_HI           8
`define SCPLLC_LVL_LO           7
`define SCPLLC_CORE_HI          2
`define SCPLLC_CORE_LO          0
`define SCPLLC_RST_REG          16'h0000
`define SCPLLC_CAL_PFD_CYCLES   5120
`define SCPLLC_SETTLE_CYCLES    64
// A read bit crosses both pin synchronisers before the host samples it,
// about ten clocks, so the half period must be longer than that.
`define SCPLLC_SCLK_HALF        12
`define SCPLLC_APB_CTRL         12'h000
`define SCPLLC_APB_STATUS       12'h004
`define SCPLLC_APB_RDATA        12'h008

`endif

// >>> inc/scpllc_pkg.sv
/*
 Types shared by both ends of the three-wire configuration port.
 Assumes scpllc_params.svh is reachable on the include path.
*/
`include "scpllc_params.svh"

package scpllc_pkg;

	typedef logic [`SCPLLC_ADDR_BITS-1:0] scpllc_addr_t;
	typedef logic [`SCPLLC_DATA_BITS-1:0] scpllc_data_t;

	typedef enum logic [1:0] {
		SCPLLC_CAL_IDLE   = 2'h0,
		SCPLLC_CAL_RUN    = 2'h1,
		SCPLLC_CAL_SETTLE = 2'h3
	} scpllc_cal_t;

	typedef enum logic [1:0] {
		SCPLLC_HS_IDLE  = 2'h0,
		SCPLLC_HS_LEAD  = 2'h1,
		SCPLLC_HS_SHIFT = 2'h3,
		SCPLLC_HS_TAIL  = 2'h2
	} scpllc_hst_t;

endpackage : scpllc_pkg

// >>> testbench/scpllc_bench.sv
/*
 Self-checking bench joining host and device ends over the link.
 Assumes a zero-wait APB slave and a shortened calibration count.
*/
`timescale 1ns/1ps
`include "scpllc_params.svh"

module scpllc_bench;
	import scpllc_pkg::*;

	logic         clk, srst, tick, psel, penable, pwrite, pready, pslverr, e;
	logic [1:0]   tc, div_sel, lvl;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, q;
	scpllc_data_t int_w, frac_w, mod_w;
	logic         frac_m, ext_o, oen, busy, lock, mux_pin;
	logic [3:0]   ratio;
	logic [2:0]   core, mux_sel;
	int           fails, n_compared, tk;

	scpllc_if link();
	scpllc_host scpllc_host_inst (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .LINK(link));
	scpllc_dev #(.CAL_CYCLES(8)) scpllc_dev_inst (.I_CLK(clk),
		.I_SRST(srst), .I_PFD_TICK(tick), .LINK(link), .O_INT_WORD(int_w),
		.O_FRAC_WORD(frac_w), .O_MOD_WORD(mod_w), .O_FRAC_MODE(frac_m),
		.O_OUT_DIV_SEL(div_sel), .O_OUT_DIV_RATIO(ratio),
		.O_OSC_OUTPUT_LEVEL(lvl), .O_OSC_CORE_SELECT(core),
		.O_EXT_OSC(ext_o), .O_OSC_OUTPUT_ENABLE(oen),
		.O_STATUS_MUX_SELECT(mux_sel), .O_CAL_BUSY(busy),
		.O_LOCKED(lock), .O_STATUS_MUX_PIN(mux_pin));
	scpllc_link_asserts scpllc_link_asserts_inst (.I_CLK(clk),
		.I_SRST(srst), .sclk(link.sclk), .cs_n(link.cs_n),
		.host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe),
		.dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Reference tick every fourth clock, so calibration spans many cycles.
	always @(posedge clk) begin
		tc <= tc + 2'h1;
		tick <= (tc == 2'h3);
	end

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, `SCPLLC_APB_STATUS, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 500);
		if (n >= 500)
			fails++;
	endtask : wait_idle

	// The wait after idle covers the device's pin synchroniser latency.
	task automatic ser(input logic rd, input scpllc_addr_t a,
		input scpllc_data_t d, input logic [4:0] nb);
		wait_idle();
		apb(1'b1, `SCPLLC_APB_CTRL, {3'h0, nb, rd, a, d});
		wait_idle();
		repeat (10) @(posedge clk);
	endtask : ser

	task automatic t_reset;
		chk("frac_mode", 1, frac_m);
		chk("locked", 1, lock);
		chk("mux_pin", 1, mux_pin);
		chk("cal_busy", 0, busy);
		chk("osc_en", 0, oen);
	endtask : t_reset

	task automatic t_path;
		scpllc_data_t w;
		for (int i = 0; i < 4; i++) begin
			w = 16'(i << 7) | 16'(i << 3) | 16'(i);
			ser(1'b0, `SCPLLC_OFS_LO_PATH, w, 5'h10);
			chk("div_sel", i, div_sel);
			chk("div_ratio", 1 << i, ratio);
			chk("level", i, lvl);
			chk("core", i, core);
			chk("ext_osc", i == 3, ext_o);
		end
		ser(1'b1, `SCPLLC_OFS_LO_PATH, 16'h0000, 5'h10);
		apb(1'b0, `SCPLLC_APB_RDATA, 32'h0);
		chk("readback", w, q[15:0]);
	endtask : t_path

	task automatic t_ctrl;
		ser(1'b0, `SCPLLC_OFS_LO_OUT_EN, 16'h0080, 5'h10);
		chk("osc_en", 1, oen);
		ser(1'b0, `SCPLLC_OFS_MUX_SEL, 16'h0010, 5'h10);
		chk("mux_sel", 1, mux_sel);
		// Several cycles, so both levels of the tick are seen.
		repeat (4) begin
			@(negedge clk);
			chk("mux_tick", tick, mux_pin);
		end
		@(posedge clk);
		ser(1'b0, `SCPLLC_OFS_MUX_SEL, 16'h0000, 5'h10);
	endtask : t_ctrl

	task automatic t_short;
		ser(1'b0, `SCPLLC_OFS_FRAC_NUM, 16'h1234, 5'h10);
		ser(1'b0, `SCPLLC_OFS_FRAC_NUM, 16'ha5ff, 5'h08);
		chk("short_write", 16'ha534, frac_w);
	endtask : t_short

	task automatic t_cal;
		ser(1'b0, `SCPLLC_OFS_MODULUS, 16'h0100, 5'h10);
		chk("mod_word", 16'h0100, mod_w);
		ser(1'b0, `SCPLLC_OFS_INT_DIV, 16'h0864, 5'h10);
		chk("int_word", 16'h0864, int_w);
		chk("frac_mode", 0, frac_m);
		chk("cal_busy", 1, busy);
		chk("locked", 0, lock);
		// Watch between edges so that registered outputs have settled.
		tk = 0;
		for (int n = 0; n < 200 && busy === 1'b1; n++) begin
			@(negedge clk);
			if (tick === 1'b1)
				tk++;
		end
		chk("cal_busy", 0, busy);
		chk("cal_ticks", 1, tk >= 4 && tk <= 8);
		tk = 0;
		for (int n = 0; n < 400 && lock !== 1'b1; n++) begin
			@(negedge clk);
			if (tick === 1'b1)
				tk++;
		end
		chk("settled", 1, lock);
		chk("settle_ticks", 1, tk >= 63);
		@(posedge clk);
	endtask : t_cal

	// A reset in mid-run must bring back the defaults checked by t_reset.
	task automatic t_rerst;
		chk("osc_en", 1, oen);
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
	endtask : t_rerst

	task automatic t_err;
		apb(1'b1, 12'h010, 32'h0);
		chk("unmapped_err", 1, e);
		apb(1'b0, `SCPLLC_APB_RDATA, 32'h0);
		chk("mapped_err", 0, e);
	endtask : t_err

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		tc = 2'h0;
		tick = 1'b0;
		srst = 1'b1;
		fails = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_path();
		t_ctrl();
		t_short();
		t_cal();
		t_err();
		t_rerst();
		end_of_test();
	end
endmodule : scpllc_bench

// >>> testbench/scpllc_link_asserts.sv
/*
 Checks on the three-wire link between the host and device ends.
 Assumes the link signals are sampled on the device clock domain.
*/
`timescale 1ns/1ps
`include "scpllc_params.svh"

module scpllc_link_asserts (
	// Clock and reset
	input  wire logic I_CLK,
	input  wire logic I_SRST,
	// Link signals
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic host_sdio_o,
	input  wire logic host_sdio_oe,
	input  wire logic dev_sdio_o,
	input  wire logic dev_sdio_oe
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SRST);

	logic       sclk_q;
	logic [5:0] rises_q;
	wire        sclk_rise = sclk && !sclk_q;
	localparam int HALF = `SCPLLC_SCLK_HALF;
	logic [4:0] hi_q;

	// Consecutive high samples of the serial clock.
	always_ff @(posedge I_CLK) begin
		if (I_SRST || !sclk)
			hi_q <= 5'h00;
		else
			hi_q <= hi_q + 5'h01;
	end

	// Rising edges of the frame, cleared while the select is idle.
	always_ff @(posedge I_CLK) begin
		sclk_q <= sclk;
		if (I_SRST || cs_n)
			rises_q <= 6'h00;
		else if (sclk_rise)
			rises_q <= rises_q + 6'h01;
	end

	property p_idle_low;
		cs_n |-> !sclk;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("serial clock moved while select idle");
	property p_lead;
		$fell(cs_n) |-> !sclk [*3];
	endproperty
	a_lead: assert property (p_lead)
		else $error("serial clock rose too soon after select");
	property p_half;
		$fell(sclk) |-> hi_q == 5'(HALF);
	endproperty
	a_half: assert property (p_half)
		else $error("serial clock high phase wrong length");
	property p_host_hold;
		sclk && sclk_q && host_sdio_oe |-> $stable(host_sdio_o);
	endproperty
	a_host_hold: assert property (p_host_hold)
		else $error("host data changed while clock high");
	property p_one_driver;
		!(host_sdio_oe && dev_sdio_oe);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive the data wire");
	property p_turn;
		$rose(dev_sdio_oe) |-> rises_q == 6'h08 && !cs_n;
	endproperty
	a_turn: assert property (p_turn)
		else $error("device drove data outside the read phase");
	property p_quiet;
		cs_n [*8] |-> !dev_sdio_oe;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("device drives while not selected");
	property p_dev_hold;
		dev_sdio_oe && sclk && sclk_q |-> $stable(dev_sdio_o);
	endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("device data changed while clock high");
	property p_frame_len;
		$rose(cs_n) |-> rises_q <= 6'h18;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame longer than twenty-four bits");

	c_full: cover property ($rose(cs_n) && rises_q == 6'h18);
	c_short: cover property ($rose(cs_n) && rises_q < 6'h18);
	c_read: cover property ($rose(dev_sdio_oe));
endmodule : scpllc_link_asserts
